/* File: core/cgd_defines.svh */
// Constants for the gate-width and debug delay register bank
`ifndef CGD_DEFINES_SVH
`define CGD_DEFINES_SVH

// -----------------------------------------------------------------------------
// Serial instruction codes (upper seven bits; bit 0 selects write or read)
// -----------------------------------------------------------------------------
`define CGD_OP_GATE_A      7'h14
`define CGD_OP_GATE_B      7'h15
`define CGD_OP_DEBUG       7'h17
`define CGD_IR_FLAG        8'h30
`define CGD_IR_DIR_BIT     0
`define CGD_IR_RESET       8'hFF
`define CGD_IR_CAPTURE     8'h01

// -----------------------------------------------------------------------------
// Register widths and reset values
// -----------------------------------------------------------------------------
`define CGD_DELAY_MIN      5'h00
`define CGD_DELAY_RESET    5'h1F
`define CGD_FLAG_RESET     1'h0

// -----------------------------------------------------------------------------
// Effective gate width span over the delay code range, and clock period
// -----------------------------------------------------------------------------
`define CGD_GATE_MIN_NS    26
`define CGD_GATE_MAX_NS    48
`define CGD_CLK_PERIOD_NS  25

`endif

/* File: core/cgd_pkg.sv */
// Types shared by the gate-width and debug delay register bank
package cgd_pkg;

    // -------------------------------------------------------------------------
    // Serial port pins, delay settings and port state
    // -------------------------------------------------------------------------
    typedef logic [4:0] cgd_delay_t;
    typedef logic [7:0] cgd_instr_t;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } cgd_jtag_in_s;

    typedef struct packed {
        cgd_delay_t gate_width_delay_port_a;
        cgd_delay_t gate_width_delay_port_b;
        cgd_delay_t debug_output_delay;
    } cgd_delays_s;

    typedef enum logic [15:0] {
        CGD_TLR    = 16'h0001,
        CGD_RTI    = 16'h0002,
        CGD_SEL_DR = 16'h0004,
        CGD_CAP_DR = 16'h0008,
        CGD_SH_DR  = 16'h0010,
        CGD_EX1_DR = 16'h0020,
        CGD_PA_DR  = 16'h0040,
        CGD_EX2_DR = 16'h0080,
        CGD_UP_DR  = 16'h0100,
        CGD_SEL_IR = 16'h0200,
        CGD_CAP_IR = 16'h0400,
        CGD_SH_IR  = 16'h0800,
        CGD_EX1_IR = 16'h1000,
        CGD_PA_IR  = 16'h2000,
        CGD_EX2_IR = 16'h4000,
        CGD_UP_IR  = 16'h8000
    } cgd_tap_e;

endpackage : cgd_pkg

/* File: core/cgd_regs.sv */
// Serially configured gate-width, debug delay and upset monitor registers
//
// Overview of operation
// RULE_01 - Two 5-bit gate-width delays, ports A and B, own codes, read and write.
// RULE_02 - Code zero means no delay, thirty-one maximum; all delays reset to 31.
// RULE_03 - Gate-width setting makes the identification gate about 26 to 48 ns.
// RULE_04 - A 5-bit read/write debug output delay with its own code.
// RULE_05 - One-bit upset monitor flag at a fixed code, read only.
// RULE_06 - Flag reads one once configuration storage upset is seen, else zero.
// RULE_07 - Rewriting the configuration storage clears the upset flag; the write that repairs a mismatch leaves it set.
// RULE_08 - Instruction code bit 0: one writes the register, zero reads it.
// RULE_09 - Data shifts after instruction load; writes take effect at update.
`timescale 1ns/1ps
`default_nettype none
`include "cgd_defines.svh"

module cgd_regs (
    input  wire logic                  clk,
    input  wire logic                  reset,
    input  wire cgd_pkg::cgd_jtag_in_s jtag_in,
    output logic                       tdo,
    output logic                       tdo_oe,
    output cgd_pkg::cgd_delays_s       delays,
    output logic                       upset_monitor_flag
);
    import cgd_pkg::*;

    // -------------------------------------------------------------------------
    // Pin synchronisers and serial clock edge detection
    // -------------------------------------------------------------------------
    cgd_jtag_in_s pin_s1_ff;
    cgd_jtag_in_s pin_s2_ff;
    logic         tck_prev_ff;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pin_s1_ff   <= '0;
            pin_s2_ff   <= '0;
            tck_prev_ff <= 1'b0;
        end else begin
            pin_s1_ff   <= jtag_in;
            pin_s2_ff   <= pin_s1_ff;
            tck_prev_ff <= pin_s2_ff.tck;
        end
    end

    wire tck_rise = pin_s2_ff.tck & ~tck_prev_ff;
    wire tck_fall = ~pin_s2_ff.tck & tck_prev_ff;
    wire tms      = pin_s2_ff.tms;
    wire tdi      = pin_s2_ff.tdi;

    // -------------------------------------------------------------------------
    // Port state machine
    // -------------------------------------------------------------------------
    cgd_tap_e state_ff;
    cgd_tap_e nxt_state;

    always_comb begin
        case (state_ff)
            CGD_TLR:    nxt_state = tms ? CGD_TLR    : CGD_RTI;
            CGD_RTI:    nxt_state = tms ? CGD_SEL_DR : CGD_RTI;
            CGD_SEL_DR: nxt_state = tms ? CGD_SEL_IR : CGD_CAP_DR;
            CGD_CAP_DR: nxt_state = tms ? CGD_EX1_DR : CGD_SH_DR;
            CGD_SH_DR:  nxt_state = tms ? CGD_EX1_DR : CGD_SH_DR;
            CGD_EX1_DR: nxt_state = tms ? CGD_UP_DR  : CGD_PA_DR;
            CGD_PA_DR:  nxt_state = tms ? CGD_EX2_DR : CGD_PA_DR;
            CGD_EX2_DR: nxt_state = tms ? CGD_UP_DR  : CGD_SH_DR;
            CGD_UP_DR:  nxt_state = tms ? CGD_SEL_DR : CGD_RTI;
            CGD_SEL_IR: nxt_state = tms ? CGD_TLR    : CGD_CAP_IR;
            CGD_CAP_IR: nxt_state = tms ? CGD_EX1_IR : CGD_SH_IR;
            CGD_SH_IR:  nxt_state = tms ? CGD_EX1_IR : CGD_SH_IR;
            CGD_EX1_IR: nxt_state = tms ? CGD_UP_IR  : CGD_PA_IR;
            CGD_PA_IR:  nxt_state = tms ? CGD_EX2_IR : CGD_PA_IR;
            CGD_EX2_IR: nxt_state = tms ? CGD_UP_IR  : CGD_SH_IR;
            CGD_UP_IR:  nxt_state = tms ? CGD_SEL_DR : CGD_RTI;
            default:    nxt_state = CGD_TLR;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_ff <= CGD_TLR;
        end else if (tck_rise) begin
            state_ff <= nxt_state;
        end
    end

    // -------------------------------------------------------------------------
    // Instruction register and decode
    // -------------------------------------------------------------------------
    cgd_instr_t ir_ff;
    cgd_instr_t ir_sh_ff;

    function automatic logic [3:0] cgd_decode(input cgd_instr_t ir);
        // One-hot select: {flag, debug, gate_b, gate_a}
        cgd_decode = {ir == `CGD_IR_FLAG,
                      ir[7:1] == `CGD_OP_DEBUG,
                      ir[7:1] == `CGD_OP_GATE_B,
                      ir[7:1] == `CGD_OP_GATE_A};
    endfunction

    wire [3:0] sel      = cgd_decode(ir_ff);
    wire       sel_long = |sel[2:0];
    wire       is_write = ir_ff[`CGD_IR_DIR_BIT];   // RULE_08

    cgd_instr_t nxt_ir_sh;
    assign nxt_ir_sh = (state_ff == CGD_CAP_IR) ? `CGD_IR_CAPTURE
                     : (state_ff == CGD_SH_IR)  ? {tdi, ir_sh_ff[7:1]}
                     : ir_sh_ff;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ir_sh_ff <= `CGD_IR_RESET;
            ir_ff    <= `CGD_IR_RESET;
        end else if (tck_rise) begin
            ir_sh_ff <= nxt_ir_sh;
            if (state_ff == CGD_TLR) begin
                ir_ff <= `CGD_IR_RESET;
            end else if (state_ff == CGD_UP_IR) begin
                ir_ff <= ir_sh_ff;
            end
        end
    end

    // -------------------------------------------------------------------------
    // Data shift path: 5 bits for delays, 1 bit for flag and bypass
    // -------------------------------------------------------------------------
    cgd_delay_t dr_sh_ff;
    cgd_delay_t gate_a_ff;
    cgd_delay_t gate_b_ff;
    cgd_delay_t debug_ff;
    logic [2:0] parity_ff;
    logic       flag_ff;

    wire cgd_delay_t capture_val = sel[0] ? gate_a_ff                    // RULE_01
                                 : sel[1] ? gate_b_ff                    // RULE_01
                                 : sel[2] ? debug_ff                     // RULE_04
                                 : sel[3] ? {4'h0, flag_ff}              // RULE_05
                                 : 5'h00;

    cgd_delay_t nxt_dr_sh;
    assign nxt_dr_sh = (state_ff == CGD_CAP_DR) ? capture_val
                     : (state_ff != CGD_SH_DR)  ? dr_sh_ff
                     : sel_long ? {tdi, dr_sh_ff[4:1]}                   // RULE_09
                     : {dr_sh_ff[4:1], tdi};

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            dr_sh_ff <= 5'h00;
        end else if (tck_rise) begin
            dr_sh_ff <= nxt_dr_sh;
        end
    end

    // -------------------------------------------------------------------------
    // Configuration storage, written at update with the write direction bit
    // -------------------------------------------------------------------------
    wire       do_update = tck_rise & (state_ff == CGD_UP_DR) & is_write;   // RULE_09
    wire [2:0] wr_en     = sel[2:0] & {3{do_update}};                       // RULE_08

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            gate_a_ff <= `CGD_DELAY_RESET;                                  // RULE_02
            gate_b_ff <= `CGD_DELAY_RESET;                                  // RULE_02
            debug_ff  <= `CGD_DELAY_RESET;                                  // RULE_02
            parity_ff <= {3{^`CGD_DELAY_RESET}};
        end else begin
            if (wr_en[0]) begin
                gate_a_ff    <= dr_sh_ff;                                   // RULE_01
                parity_ff[0] <= ^dr_sh_ff;
            end
            if (wr_en[1]) begin
                gate_b_ff    <= dr_sh_ff;                                   // RULE_01
                parity_ff[1] <= ^dr_sh_ff;
            end
            if (wr_en[2]) begin
                debug_ff     <= dr_sh_ff;                                   // RULE_04
                parity_ff[2] <= ^dr_sh_ff;
            end
        end
    end

    // -------------------------------------------------------------------------
    // Upset monitor: parity mismatch sets, a rewrite clears, set wins
    // -------------------------------------------------------------------------
    wire upset_seen = (^{gate_a_ff, parity_ff[0]})
                    | (^{gate_b_ff, parity_ff[1]})
                    | (^{debug_ff, parity_ff[2]});
    wire nxt_flag   = upset_seen | (flag_ff & ~(|wr_en));                   // RULE_06 RULE_07

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            flag_ff <= `CGD_FLAG_RESET;
        end else begin
            flag_ff <= nxt_flag;                                            // RULE_06
        end
    end

    // -------------------------------------------------------------------------
    // Serial data out, changed on the falling serial clock edge
    // -------------------------------------------------------------------------
    logic tdo_ff;
    logic oe_ff;
    wire  in_shift = (state_ff == CGD_SH_DR) | (state_ff == CGD_SH_IR);
    wire  nxt_tdo  = (state_ff == CGD_SH_IR) ? ir_sh_ff[0] : dr_sh_ff[0];

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tdo_ff <= 1'b0;
            oe_ff  <= 1'b0;
        end else if (tck_fall) begin
            tdo_ff <= nxt_tdo;
            oe_ff  <= in_shift;
        end
    end

    // -------------------------------------------------------------------------
    // Outputs: codes 0..31 drive the delay lines, gate spans 26..48 ns
    // -------------------------------------------------------------------------
    assign tdo                            = tdo_ff;
    assign tdo_oe                         = oe_ff;
    assign delays.gate_width_delay_port_a = gate_a_ff;                      // RULE_03
    assign delays.gate_width_delay_port_b = gate_b_ff;                      // RULE_03
    assign delays.debug_output_delay      = debug_ff;                       // RULE_04
    assign upset_monitor_flag             = flag_ff;                        // RULE_05

endmodule // cgd_regs

`default_nettype wire

/* File: test/cgd_regs_props.sv */
// Concurrent checks on the delay register bank ports
`timescale 1ns/1ps
`default_nettype none
`include "cgd_defines.svh"

module cgd_regs_props (
    input wire logic                  clk,
    input wire logic                  reset,
    input wire cgd_pkg::cgd_jtag_in_s jtag_in,
    input wire logic                  tdo,
    input wire logic                  tdo_oe,
    input wire cgd_pkg::cgd_delays_s  delays,
    input wire logic                  upset_monitor_flag
);
    import cgd_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_tck_low;
        !jtag_in.tck [*4];
    endsequence
    sequence s_oe_on;
        $rose(tdo_oe);
    endsequence

    a_delay_reset: assert property ($fell(reset) |-> delays == {3{`CGD_DELAY_RESET}})
        else $error("delays not at reset value");
    a_port_reset: assert property ($fell(reset) |-> !tdo_oe && !tdo && !upset_monitor_flag)
        else $error("port outputs not idle after reset");
    a_delay_on_tck: assert property ($changed(delays) |-> $past(jtag_in.tck, 1) && $past(jtag_in.tck, 2))
        else $error("delay changed outside update edge");
    a_delay_quiet: assert property (s_tck_low |-> $stable(delays))
        else $error("delay changed while clock low");
    a_tdo_on_fall: assert property ($changed(tdo) |-> !$past(jtag_in.tck, 1))
        else $error("data out moved while clock high");
    a_oe_on_fall: assert property ($changed(tdo_oe) |-> !$past(jtag_in.tck, 1))
        else $error("output enable moved while clock high");
    a_oe_hold: assert property (s_oe_on |-> tdo_oe [*4])
        else $error("output enable too short");
    a_flag_clean: assert property (!upset_monitor_flag)
        else $error("upset flag set without upset");
endmodule // cgd_regs_props

bind cgd_regs cgd_regs_props i_props (.clk(clk), .reset(reset), .jtag_in(jtag_in), .tdo(tdo),
    .tdo_oe(tdo_oe), .delays(delays), .upset_monitor_flag(upset_monitor_flag));

`default_nettype wire

/* File: test/cgd_regs_tb.sv */
// Self-checking bench for the delay register bank
`timescale 1ns/1ps
`default_nettype none
`include "cgd_defines.svh"

module cgd_regs_tb;
    import cgd_pkg::*;
    logic         clk = 1'b0;
    logic         reset = 1'b1;
    cgd_jtag_in_s jtag_in;
    logic         tdo;
    logic         tdo_oe;
    logic         upset_monitor_flag;
    cgd_delays_s  delays;
    int           bad_count = 0;
    int           n_checks = 0;
    int           cycles = 0;
    logic [4:0]   exp_d [3];
    logic [4:0]   rd;
    logic [4:0]   v;
    logic [6:0]   ops [3] = '{`CGD_OP_GATE_A, `CGD_OP_GATE_B, `CGD_OP_DEBUG};

    always #12.5 clk = ~clk;

    cgd_regs i_dut (.clk(clk), .reset(reset), .jtag_in(jtag_in), .tdo(tdo), .tdo_oe(tdo_oe),
        .delays(delays), .upset_monitor_flag(upset_monitor_flag));
    cgd_tap_host i_tap (.clk(clk), .tdo(tdo), .tdo_oe(tdo_oe), .jtag(jtag_in));

    function automatic logic [4:0] field(input cgd_delays_s d, input int k);
        return k == 0 ? d.gate_width_delay_port_a :
               k == 1 ? d.gate_width_delay_port_b : d.debug_output_delay;
    endfunction
    function automatic logic [4:0] after_access(input logic [4:0] old, input logic wr,
                                                input logic [4:0] nv);
        return wr ? nv : old;
    endfunction

    task automatic chk_delay(input string what, input logic [4:0] e, input logic [4:0] g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %0h seen %0h", what, e, g);
        end
    endtask
    task automatic chk_bit(input string what, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %0b seen %0b", what, e, g);
        end
    endtask

    task automatic access(input int k, input logic wr, input logic [4:0] nv);
        i_tap.ir({ops[k], wr});
        i_tap.dr(nv, 5, rd);
        chk_delay("captured delay", exp_d[k], rd);
        exp_d[k] = after_access(exp_d[k], wr, nv);
        chk_delay("delay output", exp_d[k], field(delays, k));
    endtask

    task automatic reset_check();
        reset = 1'b1;
        repeat (10) @(posedge clk);
        #1 reset = 1'b0;
        i_tap.tlr();
        for (int k = 0; k < 3; k++) begin
            exp_d[k] = `CGD_DELAY_RESET;
            chk_delay("reset delay", exp_d[k], field(delays, k));
        end
        chk_bit("reset flag", `CGD_FLAG_RESET, upset_monitor_flag);
        $display("test reset done");
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            test_done();
        end
    end

    initial begin
        void'($urandom(32'hB6A6));
        reset_check();
        for (int i = 0; i < 12; i++) begin
            v = i < 3 ? `CGD_DELAY_MIN : i < 6 ? `CGD_DELAY_RESET : 5'($urandom);
            access(i % 3, 1'b1, v);
            access(i % 3, 1'b0, ~v);
        end
        $display("test write read done");
        i_tap.ir(`CGD_IR_FLAG);
        i_tap.dr(5'h1F, 1, rd);
        chk_bit("flag read", 1'b0, rd[0]);
        chk_bit("flag output", 1'b0, upset_monitor_flag);
        i_tap.ir(`CGD_IR_FLAG | 8'h01);
        i_tap.dr(5'h1F, 1, rd);
        chk_bit("flag write bypass", 1'b0, rd[0]);
        chk_bit("flag after write", 1'b0, upset_monitor_flag);
        i_tap.tlr();
        for (int k = 0; k < 3; k++) chk_delay("held delay", exp_d[k], field(delays, k));
        $display("test flag done");
        reset_check();
        test_done();
    end
endmodule // cgd_regs_tb

`default_nettype wire

/* File: test/cgd_tap_host.sv */
// Serial port controller model driving the register bank
`timescale 1ns/1ps
`default_nettype none

module cgd_tap_host (
    input  wire logic             clk,
    input  wire logic             tdo,
    input  wire logic             tdo_oe,
    output cgd_pkg::cgd_jtag_in_s jtag
);
    import cgd_pkg::*;
    // Idle: clock low, data line at its pull-up level
    initial jtag = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};

    task automatic step(input logic ms, input logic di, output logic q);
        jtag.tms = ms;
        jtag.tdi = di;
        repeat (5) @(posedge clk);
        #1;
        // Released data out line reads as its pull-up
        q = tdo_oe ? tdo : 1'b1;
        jtag.tck = 1'b1;
        repeat (5) @(posedge clk);
        #1;
        jtag.tck = 1'b0;
    endtask

    task automatic shift(input int n, input logic [7:0] din, output logic [7:0] q);
        logic b;
        q = 8'h00;
        for (int i = 0; i < n; i++) step(i == n - 1, din[i], q[i]);
        step(1'b1, 1'b1, b);
        step(1'b0, 1'b1, b);
    endtask

    task automatic ir(input logic [7:0] code);
        logic [7:0] q;
        logic       b;
        step(1'b1, 1'b1, b);
        step(1'b1, 1'b1, b);
        step(1'b0, 1'b1, b);
        step(1'b0, 1'b1, b);
        shift(8, code, q);
    endtask

    task automatic dr(input logic [4:0] v, input int n, output logic [4:0] q);
        logic [7:0] qq;
        logic       b;
        step(1'b1, 1'b1, b);
        step(1'b0, 1'b1, b);
        step(1'b0, 1'b1, b);
        shift(n, {3'h0, v}, qq);
        q = qq[4:0];
    endtask

    task automatic tlr();
        logic b;
        repeat (5) step(1'b1, 1'b1, b);
        step(1'b0, 1'b1, b);
    endtask
endmodule // cgd_tap_host

`default_nettype wire
